/* File: hw/lpicd_pkg.sv */
package lpicd_pkg;

  // ************************************************************
  // Command codes and masks
  // ************************************************************
  localparam logic [7:0] LPICD_RATIO_MASK = 8'hF8;
  localparam logic [7:0] LPICD_RATIO_CODE = 8'h20;
  localparam logic [7:0] LPICD_BRIGHT_MODE = 8'h81;
  localparam logic [7:0] LPICD_IND_MASK = 8'hFE;
  localparam logic [7:0] LPICD_IND_CODE = 8'hAC;
  localparam logic [7:0] LPICD_DISP_MASK = 8'hFE;
  localparam logic [7:0] LPICD_DISP_CODE = 8'hAE;
  localparam logic [7:0] LPICD_ALLON_MASK = 8'hFE;
  localparam logic [7:0] LPICD_ALLON_CODE = 8'hA4;
  localparam logic [7:0] LPICD_RESET_CMD = 8'hE2;
  localparam logic [7:0] LPICD_NOP_CMD = 8'hE3;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int LPICD_BRIGHT_MSB = 5;
  localparam int LPICD_RATIO_MSB = 2;
  localparam int LPICD_BLINK_MSB = 1;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [2:0] LPICD_RATIO_RST = 3'h0;
  localparam logic [5:0] LPICD_BRIGHT_RST = 6'h20;
  localparam logic [1:0] LPICD_BLINK_RST = 2'h0;

  // ************************************************************
  // Blink timing at 125 MHz
  // ************************************************************
  localparam int LPICD_CLK_MHZ = 125;
  localparam int LPICD_SLOW_MS = 1000;
  localparam int LPICD_FAST_MS = 500;
  localparam int LPICD_SLOW_CYC = LPICD_SLOW_MS * 1000 * LPICD_CLK_MHZ;
  localparam int LPICD_FAST_CYC = LPICD_FAST_MS * 1000 * LPICD_CLK_MHZ;

  // Decoder modes
  typedef enum logic [1:0] {
    LPICD_NORMAL,
    LPICD_BRIGHT_WAIT,
    LPICD_IND_WAIT
  } lpicd_mode_t;

  // Power state
  typedef enum logic [1:0] {
    LPICD_ACTIVE,
    LPICD_SLEEP,
    LPICD_STANDBY
  } lpicd_pwr_t;

  // Host write port
  typedef struct packed {
    logic wr;
    logic cmd_data_sel;
    logic [7:0] data;
  } lpicd_wr_t;

endpackage

/* File: hw/lpicd_blink.sv */
`timescale 1ns/100ps
`default_nettype none
// Free-running half-period toggler for indicator blinking
module lpicd_blink
  import lpicd_pkg::*;
#(
  parameter int HALF_CYC = 4
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic run_i,
  output logic phase_o
);

  logic [31:0] cnt_q, cnt_d; // Cycle counter
  logic ph_q, ph_d; // Blink phase

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    cnt_d = cnt_q;
    ph_d = ph_q;
    if (!run_i) begin
      // Oscillator stopped: freeze
      cnt_d = cnt_q;
    end else if (cnt_q >= 32'(HALF_CYC - 1)) begin
      cnt_d = 32'h0;
      ph_d = ~ph_q;
    end else begin
      cnt_d = cnt_q + 32'h1;
    end
  end

  // Registers
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cnt_q <= 32'h0;
      ph_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      ph_q <= ph_d;
    end
  end

  assign phase_o = ph_q;

endmodule // lpicd_blink
`default_nettype wire

/* File: hw/lpicd_pwr.sv */
`timescale 1ns/100ps
`default_nettype none
// Power-save state holder
module lpicd_pwr
  import lpicd_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic enter_i,
  input wire logic leave_i,
  input wire logic ind_on_i,
  input wire logic int_reset_i,
  output lpicd_pwr_t state_o
);

  lpicd_pwr_t st_q, st_d; // Power state

  // ************************************************************
  // Power transitions
  // ************************************************************
  always_comb begin
    st_d = st_q;
    case (st_q)
      LPICD_ACTIVE: begin
        if (enter_i) begin
          st_d = ind_on_i ? LPICD_STANDBY : LPICD_SLEEP;
        end
      end
      LPICD_STANDBY: begin
        if (leave_i) begin
          st_d = LPICD_ACTIVE;
        end else if (int_reset_i) begin
          st_d = LPICD_SLEEP;
        end
      end
      LPICD_SLEEP: begin
        if (leave_i) begin
          st_d = LPICD_ACTIVE;
        end
      end
      default: st_d = LPICD_ACTIVE;
    endcase
  end

  // Registers
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      st_q <= LPICD_ACTIVE;
    end else begin
      st_q <= st_d;
    end
  end

  assign state_o = st_q;

endmodule // lpicd_pwr
`default_nettype wire

/* File: hw/lpicd_decoder.sv */
`timescale 1ns/100ps
`default_nettype none
module lpicd_decoder
  import lpicd_pkg::*;
#(
  parameter int SLOW_HALF = LPICD_SLOW_CYC / 2,
  parameter int FAST_HALF = LPICD_FAST_CYC / 2
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire lpicd_wr_t host_i,
  output logic [2:0] regulator_divider_ratio_o,
  output logic [5:0] brightness_level_o,
  output logic [1:0] indicator_blink_state_o,
  output logic indicator_on_o,
  output logic indicator_drive_output_o,
  output logic display_blank_output_o,
  output logic osc_run_o,
  output logic volt_gen_run_o,
  output logic duty_drive_run_o,
  output logic seg_com_at_supply_o,
  output logic sleep_o,
  output logic standby_o
);

  // ************************************************************
  // State
  // ************************************************************
  lpicd_mode_t mode_q, mode_d; // Two-byte command tracking
  logic [2:0] ratio_q, ratio_d; // Regulator ratio
  logic [5:0] bright_q, bright_d; // Brightness level
  logic [1:0] blink_q, blink_d; // Indicator blink state
  logic ind_on_q, ind_on_d; // Indicator on flag
  logic disp_on_q, disp_on_d; // Display on flag (blocks power save entry when set)
  logic all_on_q, all_on_d; // All-points-on flag (display on leaves save when set)
  logic cmd_stb; // Command byte strobe
  logic enter_save; // Power save entry
  logic leave_save; // Power save exit
  logic int_reset; // Internal reset command
  logic slow_ph; // 1 s blink phase
  logic fast_ph; // 0.5 s blink phase
  logic ind_drv; // Indicator drive level
  lpicd_pwr_t pwr; // Power state
  logic [7:0] d; // Command byte

  assign d = host_i.data;
  // Only writes with select low are commands
  assign cmd_stb = host_i.wr && !host_i.cmd_data_sel;

  // ************************************************************
  // Command decode
  // ************************************************************
  always_comb begin
    mode_d = mode_q;
    ratio_d = ratio_q;
    bright_d = bright_q;
    blink_d = blink_q;
    ind_on_d = ind_on_q;
    disp_on_d = disp_on_q;
    all_on_d = all_on_q;
    enter_save = 1'b0;
    leave_save = 1'b0;
    int_reset = 1'b0;
    if (cmd_stb) begin
      case (mode_q)
        LPICD_BRIGHT_WAIT: begin
          // Any byte here is data, never a command
          bright_d = d[LPICD_BRIGHT_MSB:0];
          mode_d = LPICD_NORMAL;
        end
        LPICD_IND_WAIT: begin
          blink_d = d[LPICD_BLINK_MSB:0];
          mode_d = LPICD_NORMAL;
        end
        LPICD_NORMAL: begin
          if ((d & LPICD_RATIO_MASK) == LPICD_RATIO_CODE) begin
            ratio_d = d[LPICD_RATIO_MSB:0];
          end else if (d == LPICD_BRIGHT_MODE) begin
            mode_d = LPICD_BRIGHT_WAIT;
          end else if ((d & LPICD_IND_MASK) == LPICD_IND_CODE) begin
            ind_on_d = d[0];
            // Off is single byte, no wait state
            mode_d = d[0] ? LPICD_IND_WAIT : LPICD_NORMAL;
          end else if ((d & LPICD_DISP_MASK) == LPICD_DISP_CODE) begin
            disp_on_d = d[0];
            if (d[0] && all_on_q) begin
              leave_save = 1'b1;
            end
          end else if ((d & LPICD_ALLON_MASK) == LPICD_ALLON_CODE) begin
            all_on_d = d[0];
            if (d[0] && !disp_on_q) begin
              enter_save = 1'b1;
            end else if (!d[0]) begin
              leave_save = 1'b1;
            end
          end else if (d == LPICD_RESET_CMD) begin
            // Internal reset leaves our registers alone
            int_reset = 1'b1;
          end else if (d == LPICD_NOP_CMD) begin
            mode_d = mode_q;
          end
        end
        default: mode_d = LPICD_NORMAL;
      endcase
    end
  end

  // Registers; save never clears them, so modes survive
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      mode_q <= LPICD_NORMAL;
      ratio_q <= LPICD_RATIO_RST;
      bright_q <= LPICD_BRIGHT_RST;
      blink_q <= LPICD_BLINK_RST;
      ind_on_q <= 1'b0;
      disp_on_q <= 1'b0;
      all_on_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      ratio_q <= ratio_d;
      bright_q <= bright_d;
      blink_q <= blink_d;
      ind_on_q <= ind_on_d;
      disp_on_q <= disp_on_d;
      all_on_q <= all_on_d;
    end
  end

  // ************************************************************
  // Power save
  // ************************************************************
  lpicd_pwr u_pwr (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .enter_i(enter_save),
    .leave_i(leave_save),
    .ind_on_i(ind_on_q),
    .int_reset_i(int_reset),
    .state_o(pwr)
  );

  // ************************************************************
  // Blink generators; stop with the oscillator in sleep
  // ************************************************************
  lpicd_blink #(.HALF_CYC(SLOW_HALF)) u_slow (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .run_i(pwr != LPICD_SLEEP),
    .phase_o(slow_ph)
  );

  lpicd_blink #(.HALF_CYC(FAST_HALF)) u_fast (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .run_i(pwr != LPICD_SLEEP),
    .phase_o(fast_ph)
  );

  // Indicator level from blink code
  always_comb begin
    case (blink_q)
      2'h1: ind_drv = slow_ph;
      2'h2: ind_drv = fast_ph;
      2'h3: ind_drv = 1'b1;
      default: ind_drv = 1'b0;
    endcase
    if (!ind_on_q || pwr == LPICD_SLEEP) begin
      ind_drv = 1'b0;
    end
  end

  // ************************************************************
  // Registered outputs
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      regulator_divider_ratio_o <= LPICD_RATIO_RST;
      brightness_level_o <= LPICD_BRIGHT_RST;
      indicator_blink_state_o <= LPICD_BLINK_RST;
      indicator_on_o <= 1'b0;
      indicator_drive_output_o <= 1'b0;
      display_blank_output_o <= 1'b1;
      osc_run_o <= 1'b1;
      volt_gen_run_o <= 1'b1;
      duty_drive_run_o <= 1'b1;
      seg_com_at_supply_o <= 1'b0;
      sleep_o <= 1'b0;
      standby_o <= 1'b0;
    end else begin
      regulator_divider_ratio_o <= ratio_q;
      brightness_level_o <= bright_q;
      indicator_blink_state_o <= blink_q;
      indicator_on_o <= ind_on_q;
      indicator_drive_output_o <= ind_drv;
      display_blank_output_o <= (pwr == LPICD_ACTIVE);
      osc_run_o <= (pwr != LPICD_SLEEP);
      volt_gen_run_o <= (pwr == LPICD_ACTIVE);
      duty_drive_run_o <= (pwr == LPICD_ACTIVE);
      seg_com_at_supply_o <= (pwr != LPICD_ACTIVE);
      sleep_o <= (pwr == LPICD_SLEEP);
      standby_o <= (pwr == LPICD_STANDBY);
    end
  end

endmodule // lpicd_decoder
`default_nettype wire

/* File: verification/lpicd_decoder_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module lpicd_decoder_properties
  import lpicd_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire lpicd_wr_t host_i,
  input wire logic [2:0] regulator_divider_ratio_o,
  input wire logic [5:0] brightness_level_o,
  input wire logic [1:0] indicator_blink_state_o,
  input wire logic indicator_on_o,
  input wire logic indicator_drive_output_o,
  input wire logic display_blank_output_o,
  input wire logic osc_run_o,
  input wire logic volt_gen_run_o,
  input wire logic duty_drive_run_o,
  input wire logic seg_com_at_supply_o,
  input wire logic sleep_o,
  input wire logic standby_o
);
  // ****
  // Pairing tracker
  // ****
  logic cmd; // Command byte taken at this edge
  logic [1:0] wait_q; // 0 normal, 1 level byte due, 2 blink byte due
  logic [1:0] wait_d;
  assign cmd = host_i.wr && !host_i.cmd_data_sel;
  // Own copy of the wait state, so a stuck design mode shows up
  always_comb begin
    wait_d = wait_q;
    if (cmd) begin
      wait_d = 2'h0;
      if (wait_q == 2'h0 && host_i.data == LPICD_BRIGHT_MODE) wait_d = 2'h1;
      if (wait_q == 2'h0 && host_i.data == (LPICD_IND_CODE | 8'h01)) wait_d = 2'h2;
    end
    if (!reset_n_i) wait_d = 2'h0;
  end
  always_ff @(posedge clk_i) begin
    wait_q <= wait_d;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // ****
  // Properties
  // ****
  a_ratio_load: assert property (
    cmd && wait_q == 2'h0 && (host_i.data & LPICD_RATIO_MASK) == LPICD_RATIO_CODE
    |-> ##2 regulator_divider_ratio_o == 3'($past(host_i.data, 2)))
    else $error("ratio not loaded");
  a_bright_load: assert property (
    cmd && wait_q == 2'h1 |-> ##2 brightness_level_o == 6'($past(host_i.data, 2)))
    else $error("brightness not loaded");
  a_blink_load: assert property (
    cmd && wait_q == 2'h2 |-> ##2 indicator_blink_state_o == 2'($past(host_i.data, 2)))
    else $error("blink state not loaded");
  a_ind_off: assert property (
    cmd && wait_q == 2'h0 && host_i.data == LPICD_IND_CODE |-> ##2 !indicator_on_o)
    else $error("indicator off ignored");
  a_blank_save: assert property (
    (sleep_o || standby_o) |-> !display_blank_output_o)
    else $error("blank output high in save");
  a_sleep_osc: assert property (
    sleep_o |-> !osc_run_o && !volt_gen_run_o)
    else $error("sleep left oscillator or generator on");
  a_sleep_seg: assert property (
    sleep_o |-> seg_com_at_supply_o && !duty_drive_run_o)
    else $error("sleep outputs not at supply");
  a_standby_run: assert property (
    standby_o |-> osc_run_o && !volt_gen_run_o && !duty_drive_run_o && seg_com_at_supply_o)
    else $error("standby run flags wrong");
  a_steady_drive: assert property (
    (indicator_on_o && indicator_blink_state_o == 2'h3 && !sleep_o && !standby_o) [*3]
    |-> indicator_drive_output_o)
    else $error("steady indicator not driven");
  a_drive_off: assert property (
    !indicator_on_o [*3] |-> !indicator_drive_output_o)
    else $error("indicator driven while off");
endmodule // lpicd_decoder_properties
bind lpicd_decoder lpicd_decoder_properties lpicd_decoder_properties_i (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .host_i(host_i),
  .regulator_divider_ratio_o(regulator_divider_ratio_o),
  .brightness_level_o(brightness_level_o), .indicator_blink_state_o(indicator_blink_state_o),
  .indicator_on_o(indicator_on_o), .indicator_drive_output_o(indicator_drive_output_o),
  .display_blank_output_o(display_blank_output_o), .osc_run_o(osc_run_o),
  .volt_gen_run_o(volt_gen_run_o), .duty_drive_run_o(duty_drive_run_o),
  .seg_com_at_supply_o(seg_com_at_supply_o), .sleep_o(sleep_o), .standby_o(standby_o));
`default_nettype wire

/* File: verification/lpicd_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Host side: one byte per cycle, driven at falling edges
module lpicd_host_model
  import lpicd_pkg::*;
(
  input wire logic clk_i,
  output lpicd_wr_t host_o
);
  initial host_o = '0; // Quiet bus before reset release
  // Caller sits at a falling edge; strobe stays up for back-to-back bytes
  task automatic send(input logic sel, input logic [7:0] b);
    host_o <= '{1'b1, sel, b};
    @(negedge clk_i);
  endtask
  // Released bus shows inverted data so a stale byte never looks valid
  task automatic idle();
    host_o <= '{1'b0, 1'b0, ~host_o.data};
    @(negedge clk_i);
  endtask
endmodule // lpicd_host_model
`default_nettype wire

/* File: verification/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("BAD %s expected %h seen %h", nm, e, a); end end
module testbench
  import lpicd_pkg::*;
;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  lpicd_wr_t host;
  logic [2:0] ratio;
  logic [5:0] bright;
  logic [1:0] blink;
  logic ind, drv, blank, osc, volt, duty, seg, slp, stby;
  int mismatches = 0;
  int total_checks = 0;
  // Reference state: pwr 0 active, 1 sleep, 2 standby
  int m_ratio = 0, m_bright = 32, m_blink = 0, m_ind = 0, m_wait = 0;
  int m_pwr = 0, m_disp = 0, m_allon = 0;
  logic [7:0] ops[$] = '{8'h20, 8'h81, 8'hAC, 8'hAD, 8'hAE, 8'hAF, 8'hA4, 8'hE2, 8'hE3, 8'hA6};
  logic [7:0] vals[$] = '{8'h00, 8'hFF, 8'hE3, 8'hAC, 8'hA5, 8'h20};
  logic [7:0] op;
  always #4 clk_i = ~clk_i;
  lpicd_host_model lpicd_host_model_i (.clk_i(clk_i), .host_o(host));
  lpicd_decoder #(.SLOW_HALF(4), .FAST_HALF(2)) lpicd_decoder_i (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .host_i(host),
    .regulator_divider_ratio_o(ratio), .brightness_level_o(bright),
    .indicator_blink_state_o(blink), .indicator_on_o(ind),
    .indicator_drive_output_o(drv), .display_blank_output_o(blank),
    .osc_run_o(osc), .volt_gen_run_o(volt), .duty_drive_run_o(duty),
    .seg_com_at_supply_o(seg), .sleep_o(slp), .standby_o(stby));
  // ****
  // Send one byte and step the reference
  // ****
  task automatic put(input logic sel, input logic [7:0] b);
    lpicd_host_model_i.send(sel, b);
    if (sel) return; // Display data never decoded
    if (m_wait != 0) begin
      if (m_wait == 1) m_bright = b[5:0];
      else m_blink = b[1:0];
      m_wait = 0;
    end else if (b[7:3] == 5'h04) m_ratio = b[2:0];
    else if (b == 8'h81) m_wait = 1;
    else if (b[7:1] == 7'h56) begin
      m_ind = b[0];
      m_wait = b[0] ? 2 : 0;
    end else if (b[7:1] == 7'h57) begin
      m_disp = b[0];
      if (b[0] && m_allon) m_pwr = 0;
    end else if (b[7:1] == 7'h52) begin
      if (b[0] && !m_disp && m_pwr == 0) m_pwr = m_ind ? 2 : 1;
      if (!b[0]) m_pwr = 0;
      m_allon = b[0];
    end else if (b == 8'hE2 && m_pwr == 2) m_pwr = 1;
  endtask
  // Let outputs settle, then compare everything
  task automatic check_all();
    logic [1:0] seen; // Drive levels seen while blinking
    seen = 2'h0;
    repeat (4) lpicd_host_model_i.idle();
    // Blink phase is free-running, so blinking codes only need both levels
    if (m_ind != 0 && m_pwr != 1 && (m_blink == 1 || m_blink == 2)) begin
      repeat (10) begin
        @(posedge clk_i);
        #1 seen = seen | (2'h1 << drv);
      end
      @(negedge clk_i);
      `CHK("blink_seen", 2'h3, seen)
    end else begin
      `CHK("drive", 1'(m_ind != 0 && m_pwr != 1 && m_blink == 3), drv)
    end
    `CHK("ratio", 3'(m_ratio), ratio)
    `CHK("bright", 6'(m_bright), bright)
    `CHK("blink", 2'(m_blink), blink)
    `CHK("ind_on", 1'(m_ind), ind)
    `CHK("power", {m_pwr == 1, m_pwr == 2, m_pwr == 0, m_pwr != 1, m_pwr == 0, m_pwr == 0,
      m_pwr != 0}, {slp, stby, blank, osc, volt, duty, seg})
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    void'($urandom(24697));
    repeat (5) @(negedge clk_i);
    reset_n_i = 1'b1;
    check_all();
    for (int i = 0; i < 8; i++) begin
      put(1'b0, 8'h20 | 8'(i));
      check_all();
    end
    // Command-like bytes must land as level data; last one is the reset default
    foreach (vals[i]) begin
      put(1'b0, 8'h81);
      put(1'b0, vals[i]);
      check_all();
    end
    for (int i = 0; i < 4; i++) begin
      put(1'b0, 8'hAD);
      put(1'b0, (8'($urandom) & 8'hFC) | 8'(i));
      check_all();
    end
    put(1'b0, 8'hAC);
    put(1'b0, 8'h25);
    check_all();
    put(1'b0, 8'hE3);
    put(1'b1, 8'h81);
    put(1'b0, 8'h22);
    check_all();
    for (int s = 0; s < 2; s++) begin
      if (s != 0) begin
        put(1'b0, 8'hAD);
        put(1'b0, 8'h03);
      end else put(1'b0, 8'hAC);
      put(1'b0, 8'hAE);
      put(1'b0, 8'hA5);
      check_all();
      put(1'b0, 8'h26);
      put(1'b0, 8'hE2);
      check_all();
      put(1'b0, 8'hA4);
      check_all();
    end
    put(1'b0, 8'hA5);
    put(1'b0, 8'hAF);
    check_all();
    put(1'b0, 8'hA4);
    // Random mix, display data interleaved; indicator left alone by others
    repeat (150) begin
      op = ops[$urandom_range(9)];
      if (op == 8'h20) op = op | 8'($urandom_range(7));
      put(1'b1, 8'($urandom));
      put(1'b0, op);
      if (op == 8'h81 || op == 8'hAD) put(1'b0, 8'($urandom));
      check_all();
    end
    print_verdict();
  end
  // Hang guard, well past the expected run
  initial begin
    #100000;
    mismatches++;
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
